// >>> rtl/rbls_top.v
`timescale 1ns/1ps
`include "rbls_regs.vh"
module rbls_top #(
   // Test-engine address width; this range spans all four quadrants, each RBLS_QUAD_STEP words apart
   parameter AW = 15
) (
   // Single clock and synchronous master reset
   input wire sys_clk,
   input wire reset,
   // Diagnostic pin, high selects test mode and the failing-address view
   input wire test_mode,
   // Register port, one-cycle strobes with a word address
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_addr,
   input wire [15:0] reg_wdata,
   output reg [15:0] reg_rdata,
   // Normal-mode word shown at the shared address while the pin is low
   input wire [15:0] first_remote_terminal_msg_info,
   // RAM test engine; enable is bit 15, kept by the neighbouring block
   input wire ram_check_enable,
   output wire ram_check_run,
   input wire ram_check_done,
   input wire ram_check_error,
   input wire [AW-1:0] ram_check_addr,
   // Loopback engine; configuration out, completion and error reports in
   output wire loopback_run,
   output wire loopback_analog_select,
   output wire loopback_sync_select,
   output wire loopback_bus_select,
   output wire loopback_drive_a,
   output wire loopback_drive_b,
   input wire loopback_done,
   input wire loopback_manchester_err,
   input wire loopback_parity_err,
   input wire loopback_sync_err,
   input wire loopback_data_mismatch
);
   reg ram_check_launch_bit_r;
   reg ram_check_pass_flag_r;
   reg ram_check_fail_flag_r;
   reg [15:0] fail_addr_r;
   reg analog_r;
   reg sync_r;
   reg bus_r;
   reg loopback_launch_bit_r;
   reg loopback_pass_flag_r;
   reg loopback_fail_flag_r;
   reg lb_err_r;
   wire ctrl_wr;
   wire ram_go;
   wire lb_go;
   wire lb_err_now;
   // Assembled control word and the read data next value
   reg [15:0] ctrl_word;
   reg [15:0] reg_rdata_nxt;

   assign ctrl_wr = reg_wr && (reg_addr == `RBLS_ADDR_CTRL);
   assign ram_go = ctrl_wr && reg_wdata[`RBLS_B_RSTRT] && test_mode && ram_check_enable && !ram_check_launch_bit_r;
   assign lb_go = ctrl_wr && reg_wdata[`RBLS_B_LSTRT] && test_mode && !loopback_launch_bit_r;
   assign lb_err_now = loopback_manchester_err | loopback_parity_err | loopback_sync_err | loopback_data_mismatch;

   assign ram_check_run = ram_check_launch_bit_r;
   assign loopback_run = loopback_launch_bit_r;
   assign loopback_bus_select = bus_r;
   assign loopback_sync_select = sync_r;
   assign loopback_analog_select = analog_r;
   assign loopback_drive_a = loopback_launch_bit_r && analog_r && !bus_r;
   assign loopback_drive_b = loopback_launch_bit_r && analog_r && bus_r;

   // RAM self-test sequencing; the address is captured once, at the first error,
   // so a burst of later errors cannot hide where the damage began.
   // The whole AW-bit address is kept, quadrant bits included, so it
   // points straight at the cell that really failed.
   // An error reported in the done cycle still counts against the pass flag.
   always @(posedge sys_clk) begin
      if (reset) begin
         ram_check_launch_bit_r <= 1'b0;
         ram_check_pass_flag_r <= 1'b0;
         ram_check_fail_flag_r <= 1'b0;
         fail_addr_r <= `RBLS_RESET16;
      end else if (ram_go) begin
         ram_check_launch_bit_r <= 1'b1;
         ram_check_pass_flag_r <= 1'b0;
         ram_check_fail_flag_r <= 1'b0;
      end else if (ram_check_launch_bit_r) begin
         if (ram_check_error && !ram_check_fail_flag_r) begin
            ram_check_fail_flag_r <= 1'b1;
            fail_addr_r <= {{(16-AW){1'b0}}, ram_check_addr};
         end
         if (ram_check_done) begin
            ram_check_launch_bit_r <= 1'b0;
            ram_check_pass_flag_r <= !(ram_check_fail_flag_r || ram_check_error);
         end
      end
   end

   // Loopback configuration bits 5 to 3.
   // Frozen while a test runs, so the word on the wire is never torn
   // between two sync types or two buses; a write then changes nothing here.
   always @(posedge sys_clk) begin
      if (reset) begin
         analog_r <= 1'b0;
         sync_r <= 1'b0;
         bus_r <= 1'b0;
      end else if (ctrl_wr && !loopback_launch_bit_r) begin
         analog_r <= reg_wdata[`RBLS_B_ALOG];
         sync_r <= reg_wdata[`RBLS_B_SYNC];
         bus_r <= reg_wdata[`RBLS_B_BUS];
      end
   end

   // Loopback sequencing; errors are gathered over the whole word and
   // judged only when the far side reports done, so a short glitch on one
   // error line is never lost between samples
   always @(posedge sys_clk) begin
      if (reset) begin
         loopback_launch_bit_r <= 1'b0;
         loopback_pass_flag_r <= 1'b0;
         loopback_fail_flag_r <= 1'b0;
         lb_err_r <= 1'b0;
      end else if (lb_go) begin
         loopback_launch_bit_r <= 1'b1;
         loopback_pass_flag_r <= 1'b0;
         loopback_fail_flag_r <= 1'b0;
         lb_err_r <= 1'b0;
      end else if (loopback_launch_bit_r) begin
         if (lb_err_now) begin
            lb_err_r <= 1'b1;
         end
         if (loopback_done) begin
            loopback_launch_bit_r <= 1'b0;
            loopback_fail_flag_r <= lb_err_r | lb_err_now;
            loopback_pass_flag_r <= !(lb_err_r | lb_err_now);
         end
      end
   end

   // Control and status word, built field by field from the named positions;
   // the pattern-select field lives in another block and reads as zero here
   always @* begin
      ctrl_word = `RBLS_RESET16;
      ctrl_word[`RBLS_B_ENA] = ram_check_enable;
      ctrl_word[`RBLS_B_RSTRT] = ram_check_launch_bit_r;
      ctrl_word[`RBLS_B_RPASS] = ram_check_pass_flag_r;
      ctrl_word[`RBLS_B_RFAIL] = ram_check_fail_flag_r;
      ctrl_word[`RBLS_B_ALOG] = analog_r;
      ctrl_word[`RBLS_B_SYNC] = sync_r;
      ctrl_word[`RBLS_B_BUS] = bus_r;
      ctrl_word[`RBLS_B_LSTRT] = loopback_launch_bit_r;
      ctrl_word[`RBLS_B_LPASS] = loopback_pass_flag_r;
      ctrl_word[`RBLS_B_LFAIL] = loopback_fail_flag_r;
   end

   // Read data next value; it holds between reads, so a slow host may sample late
   always @* begin
      reg_rdata_nxt = reg_rdata;
      if (reg_rd) begin
         case (reg_addr)
            `RBLS_ADDR_FAIL: begin
               if (test_mode) begin
                  reg_rdata_nxt = fail_addr_r;
               end else begin
                  reg_rdata_nxt = first_remote_terminal_msg_info;
               end
            end
            `RBLS_ADDR_CTRL: begin
               reg_rdata_nxt = ctrl_word;
            end
            default: begin
               // Unmapped reads return zero
               reg_rdata_nxt = `RBLS_RESET16;
            end
         endcase
      end
   end

   // Read data register; data outputs leave from flip-flops
   always @(posedge sys_clk) begin
      if (reset) begin
         reg_rdata <= `RBLS_RESET16;
      end else begin
         reg_rdata <= reg_rdata_nxt;
      end
   end
endmodule // rbls_top

// >>> rtl/rbls_regs.vh
`ifndef RBLS_REGS_VH
`define RBLS_REGS_VH
`define RBLS_ADDR_FAIL 16'h001b
`define RBLS_ADDR_CTRL 16'h0028
`define RBLS_B_ENA 15
`define RBLS_B_RSTRT 10
`define RBLS_B_RPASS 9
`define RBLS_B_RFAIL 8
`define RBLS_B_ALOG 5
`define RBLS_B_SYNC 4
`define RBLS_B_BUS 3
`define RBLS_B_LSTRT 2
`define RBLS_B_LPASS 1
`define RBLS_B_LFAIL 0
`define RBLS_QUAD_STEP 15'h2000
`define RBLS_RESET16 16'h0000
`endif

// >>> test/rbls_monitor.sv
`timescale 1ns/1ps
module rbls_monitor(
input wire sys_clk,
input wire reset,
input wire test_mode,
input wire reg_wr,
input wire reg_rd,
input wire [15:0] reg_addr,
input wire [15:0] reg_wdata,
input wire [15:0] reg_rdata,
input wire ram_check_run,
input wire ram_check_done,
input wire loopback_run,
input wire loopback_analog_select,
input wire loopback_bus_select,
input wire loopback_drive_a,
input wire loopback_drive_b);
default clocking @(posedge sys_clk); endclocking
default disable iff (reset);
// Control write strobe
wire cw = reg_wr && reg_addr == 16'h0028;
property p_z; reg_rd && reg_addr == 16'h0028 |=> reg_rdata[7:6] == 2'h0; endproperty
a_z: assert property (p_z) else $error("spare bits set");
property p_r; $rose(ram_check_run) |-> $past(cw && reg_wdata[10] && test_mode); endproperty
a_r: assert property (p_r) else $error("ram run no launch");
property p_d; !loopback_analog_select |-> !loopback_drive_a && !loopback_drive_b; endproperty
a_d: assert property (p_d) else $error("digital drives");
property p_a; loopback_run && loopback_analog_select |-> loopback_drive_b == loopback_bus_select; endproperty
a_a: assert property (p_a) else $error("bus choice");
property p_i; !loopback_run |-> !loopback_drive_a && !loopback_drive_b; endproperty
a_i: assert property (p_i) else $error("idle drive");
property p_s; cw && reg_wdata[10] && !test_mode && !ram_check_run |=> !ram_check_run; endproperty
a_s: assert property (p_s) else $error("ram launch taken");
property p_l; cw && reg_wdata[2] && !test_mode && !loopback_run |=> !loopback_run; endproperty
a_l: assert property (p_l) else $error("loop launch taken");
sequence s_end; ram_check_run && ram_check_done; endsequence
property p_e; s_end |=> !ram_check_run; endproperty
a_e: assert property (p_e) else $error("run not cleared");
endmodule // rbls_monitor
bind rbls_top rbls_monitor u_mon(.*);

// >>> test/rbls_ram_model.sv
`timescale 1ns/1ps
// Test engine stand-in, one address a cycle
module rbls_ram_model(
input wire sys_clk,
input wire run,
input wire [14:0] bad,
output reg done,
output wire err,
output reg [14:0] addr);
assign err = run && addr == bad;
always @(posedge sys_clk) begin
addr <= run && !done ? addr + 15'h0001 : 15'h0000;
done <= run && addr == 15'h0012;
end
endmodule // rbls_ram_model

// >>> test/ram_bist_loopback_status_tb.sv
`timescale 1ns/1ps
module ram_bist_loopback_status_tb;
reg sys_clk = 0, reset = 1, tm = 0, wr = 0, rd = 0, lbd = 0;
reg [15:0] a = 0, d = 0, msg = 0;
reg [14:0] bad = 15'h7fff;
wire [15:0] q;
wire run, dn, er, la, lb;
wire [14:0] ad;
reg en = 1;
reg [3:0] le = 0;
wire lr, lan, ls, lbs;
// Expected control word with neither test running
function [15:0] ctl(input e, input [1:0] rf, input [2:0] cfg, input [1:0] lf);
ctl = {e, 5'h00, rf, 2'h0, cfg, 1'b0, lf};
endfunction
integer errors = 0, samples_checked = 0, cyc = 0, seed = 32'h54a1, i;
always #10 sys_clk = ~sys_clk;
rbls_top dut(.sys_clk(sys_clk), .reset(reset), .test_mode(tm), .reg_wr(wr), .reg_rd(rd), .reg_addr(a),
.reg_wdata(d), .reg_rdata(q), .first_remote_terminal_msg_info(msg), .ram_check_enable(en),
.ram_check_run(run), .ram_check_done(dn), .ram_check_error(er), .ram_check_addr(ad), .loopback_run(lr),
.loopback_analog_select(lan), .loopback_sync_select(ls), .loopback_bus_select(lbs), .loopback_drive_a(la),
.loopback_drive_b(lb), .loopback_done(lbd), .loopback_manchester_err(le[0]), .loopback_parity_err(le[1]),
.loopback_sync_err(le[2]), .loopback_data_mismatch(le[3]));
rbls_ram_model rm(.sys_clk(sys_clk), .run(run), .bad(bad), .done(dn), .err(er), .addr(ad));
task chk(input [15:0] s, input [15:0] e); begin
samples_checked = samples_checked + 1;
if (s !== e) begin errors = errors + 1; $display("MISMATCH %0t %h %h", $time, s, e); end
end endtask
task wr16(input [15:0] x, input [15:0] y); begin
@(negedge sys_clk) wr = 1; a = x; d = y;
@(negedge sys_clk) wr = 0;
end endtask
task rd16(input [15:0] x, input [15:0] e); begin
@(negedge sys_clk) rd = 1; a = x;
@(negedge sys_clk) rd = 0; chk(q, e);
end endtask
task tally_and_finish; begin
$display("checks %0d errors %0d", samples_checked, errors);
if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
else $display("SIMULATION FAILED");
$finish;
end endtask
// Hang guard
always @(posedge sys_clk) begin cyc = cyc + 1; if (cyc == 4000) begin errors = errors + 1; tally_and_finish; end end
initial begin
msg = $random(seed);
repeat (10) @(negedge sys_clk);
reset = 0;
rd16(16'h0028, 16'h8000);
rd16(16'h001b, msg);
wr16(16'h0028, 16'h0404);
rd16(16'h0028, 16'h8000);
tm = 1;
en = 0;
wr16(16'h0028, 16'h0400);
rd16(16'h0028, ctl(1'b0, 2'h0, 3'h0, 2'h0));
en = 1;
// Alternate failing and clean runs so each launch must clear the last result
for (i = 0; i < 4; i = i + 1) begin
bad = i[0] ? $random(seed) & 15'h000f : 15'h7fff;
wr16(16'h0028, 16'h0400);
repeat (30) if (run) @(negedge sys_clk);
rd16(16'h0028, i[0] ? 16'h8100 : 16'h8200);
if (i[0]) rd16(16'h001b, {1'h0, bad});
end
wr16(16'h0028, 16'h00fc);
chk({la, lb}, 16'h0001);
chk({lr, lan, ls, lbs}, 16'h000f);
lbd = 1;
@(negedge sys_clk) lbd = 0;
rd16(16'h0028, 16'h813a);
wr16(16'h0028, 16'h0004);
chk({la, lb}, 16'h0000);
chk({lr, lan, ls, lbs}, 16'h0008);
le = 4'h1 << ($random(seed) & 3);
lbd = 1;
@(negedge sys_clk) lbd = 0;
le = 0;
rd16(16'h0028, ctl(1'b1, 2'h1, 3'h0, 2'h1));
// Master reset with both tests idle
reset = 1;
repeat (2) @(negedge sys_clk);
reset = 0;
chk({lr, lan, ls, lbs}, 16'h0000);
rd16(16'h0028, ctl(1'b1, 2'h0, 3'h0, 2'h0));
tally_and_finish;
end
endmodule // ram_bist_loopback_status_tb
